// >>> verilog/sbc_pkg.sv
// Package: constants, types and helpers for the bank command state logic
`default_nettype none
package sbc_pkg;
  // Register byte offsets
  localparam logic [3:0]  REG_CFG      = 4'h0;
  localparam logic [3:0]  REG_STAT     = 4'h4;
  localparam logic [3:0]  REG_ERR      = 4'h8;
  // Config field positions
  localparam int          CFG_CL_BIT   = 0;
  localparam int          CFG_BL_LSB   = 1;
  localparam int          CFG_WR_LSB   = 4;
  localparam int          CFG_RP_LSB   = 8;
  localparam int          CFG_RCD_LSB  = 12;
  localparam int          CFG_XSR_LSB  = 16;
  localparam int          CFG_W        = 24;
  // Reset: read_latency 2, burst 4, write_recovery_time 1, precharge_period 2,
  // row_to_column_delay 2, self_refresh_exit_time 8 (all in device clocks)
  localparam logic [23:0] CFG_RST      = 24'h082216;
  // Error flag positions
  localparam int          ERR_CMD_BIT  = 0;
  localparam int          ERR_PWR_BIT  = 1;
  // Status field positions
  localparam int          STAT_PWR_LSB = 16;
  localparam int          STAT_BST_BIT = 19;

  typedef enum logic [3:0] {
    BK_IDLE  = 4'h0,
    BK_ACTV  = 4'h1,
    BK_ROW   = 4'h2,
    BK_RD    = 4'h3,
    BK_WR    = 4'h4,
    BK_RDAP  = 4'h5,
    BK_WRAP  = 4'h6,
    BK_RECOV = 4'h7,
    BK_PRE   = 4'h8
  } sbc_bank_st_t;

  typedef enum logic [2:0] {
    PM_RUN  = 3'h0,
    PM_PDN  = 3'h1,
    PM_SREF = 3'h2,
    PM_SUSP = 3'h3,
    PM_DPD  = 3'h4,
    PM_XSR  = 3'h5
  } sbc_pwr_t;

  typedef enum logic [3:0] {
    CMD_INH = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACT = 4'h2,
    CMD_RD  = 4'h3,
    CMD_WR  = 4'h4,
    CMD_BST = 4'h5,
    CMD_PRE = 4'h6,
    CMD_REF = 4'h7,
    CMD_LMR = 4'h8
  } sbc_cmd_t;

  // Command bus pins as sampled
  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       cke;
    logic       dqm;
    logic [1:0] ba;
    logic       a10;
  } sbc_pins_t;

  typedef struct packed {
    sbc_bank_st_t st;
    logic [7:0]   cnt;
  } sbc_bank_t;

  typedef sbc_bank_t [3:0] sbc_banks_t;

  // Read pipeline slot
  typedef struct packed {
    logic       v;
    logic [1:0] bank;
  } sbc_slot_t;

  function automatic sbc_cmd_t sbc_decode(input sbc_pins_t p);
    sbc_cmd_t c;
    c = CMD_INH;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'h7:    c = CMD_NOP;
        3'h3:    c = CMD_ACT;
        3'h5:    c = CMD_RD;
        3'h4:    c = CMD_WR;
        3'h6:    c = CMD_BST;
        3'h2:    c = CMD_PRE;
        3'h1:    c = CMD_REF;
        default: c = CMD_LMR;
      endcase
    end
    return c;
  endfunction

  // Zero counts would skip a state, so they act as one
  function automatic logic [7:0] sbc_cnt(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction
endpackage
`default_nettype wire

// >>> verilog/sbc_bank_ctrl.sv
// Bank command and state logic with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
//
// How it works
// - Other-bank access interrupts auto-precharge burst, precharges it
// - Read-over-read cuts old data after read latency
// - Interrupted auto-precharge read precharges at new READ
// - WRITE stops auto-precharge read, precharge starts immediately
// - New read data appears read latency later
// - Read-over-write: store until prior clock, recover
// - Write-over-write: precharge after write recovery time
// - Last stored element precedes the interrupting WRITE
// - Power-down exit gives idle banks next edge
// - Clock suspend exit: commands recognized next edge
// - Terminate code means deep power-down when clock-enable drops with all banks idle
// - Idle only after full precharge period
// - Row active after row-to-column delay, no burst
// - Idle bank takes ACTIVE, refresh, mode load, PRECHARGE
// - Row-active bank takes READ, WRITE, PRECHARGE
// - PRECHARGE truncates plain read burst; others accepted
// - PRECHARGE truncates plain write burst; others accepted
// - Activating becomes active; precharging becomes idle
// - Auto-precharge read busy until precharge period ends
// - Burst terminate acts on most recent burst
module sbc_bank_ctrl
  import sbc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        link_clk,
  input  wire sbc_pins_t   pins_in,
  output logic             rd_drive,
  output logic [1:0]       rd_bank,
  output logic             wr_store,
  output logic [1:0]       wr_bank
);

  typedef struct packed {
    logic                 clk_s1;
    logic                 clk_s2;
    logic                 clk_s3;
    sbc_pins_t            pins_s1;
    sbc_pins_t            pins_s2;
    logic                 cke_prev;
    logic                 dqm_prev;
    sbc_banks_t           bank;
    sbc_pwr_t             pwr;
    logic [7:0]           pcnt;
    logic                 burst_act;
    logic                 burst_wr;
    logic [1:0]           burst_bank;
    logic [2:0]           burst_left;
    sbc_slot_t            pipe0;
    sbc_slot_t            pipe1;
    logic                 rd_drive;
    logic [1:0]           rd_bank;
    logic                 wr_store;
    logic [1:0]           wr_bank;
    logic [CFG_W-1:0]     cfg;
    logic [1:0]           err;
    logic                 dph_wr;
    logic [3:0]           dph_addr;
    logic [31:0]          hrdata;
  } sbc_state_t;

  sbc_state_t st_ff;
  sbc_state_t nxt_st;

  logic       lk_edge;
  sbc_cmd_t   cmd;
  logic [1:0] cba;
  logic       all_idle;
  logic       run_edge;
  logic       intr;
  logic       ahb_take;

  ////////////////////////////////////////////////////////////////////////
  // Shared decode
  assign lk_edge  = st_ff.clk_s2 & ~st_ff.clk_s3;
  assign cmd      = sbc_decode(st_ff.pins_s2);
  assign cba      = st_ff.pins_s2.ba;
  assign run_edge = lk_edge & (st_ff.pwr == PM_RUN) & st_ff.cke_prev
                    & st_ff.pins_s2.cke;
  assign intr     = run_edge & ((cmd == CMD_RD) | (cmd == CMD_WR))
                    & st_ff.burst_act & (st_ff.burst_bank != cba);
  assign ahb_take = hsel & htrans[1] & hready & (hsize == 3'h2);

  always_comb begin
    all_idle = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (st_ff.bank[i].st != BK_IDLE) all_idle = 1'b0;
    end
  end

  // Burst owner leaves its burst state; auto-precharge banks go on by themselves
  function automatic sbc_bank_t release_bank(input sbc_bank_t b,
                                             input logic [7:0] rp,
                                             input logic [7:0] wr);
    sbc_bank_t r;
    r = b;
    case (b.st)
      BK_RD, BK_WR: r.st = BK_ROW;
      BK_RDAP: begin
        r.st  = BK_PRE;
        r.cnt = rp;
      end
      BK_WRAP: begin
        r.st  = BK_RECOV;
        r.cnt = wr;
      end
      default: r = b;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [7:0] rp_c;
    logic [7:0] wr_c;
    logic [7:0] rcd_c;
    logic       go;
    logic       bank_ok;
    sbc_slot_t  sel;
    rp_c    = sbc_cnt({4'h0, st_ff.cfg[CFG_RP_LSB +: 4]});
    wr_c    = sbc_cnt({4'h0, st_ff.cfg[CFG_WR_LSB +: 4]});
    rcd_c   = sbc_cnt({4'h0, st_ff.cfg[CFG_RCD_LSB +: 4]});
    go      = 1'b0;
    bank_ok = 1'b0;
    sel     = st_ff.cfg[CFG_CL_BIT] ? st_ff.pipe1 : st_ff.pipe0;
    nxt_st          = st_ff;
    nxt_st.clk_s1   = link_clk;
    nxt_st.clk_s2   = st_ff.clk_s1;
    nxt_st.clk_s3   = st_ff.clk_s2;
    nxt_st.pins_s1  = pins_in;
    nxt_st.pins_s2  = st_ff.pins_s1;
    nxt_st.wr_store = 1'b0;
    if (lk_edge) begin
      nxt_st.cke_prev = st_ff.pins_s2.cke;
      nxt_st.dqm_prev = st_ff.pins_s2.dqm;
      case (st_ff.pwr)
        PM_RUN: begin
          if (st_ff.cke_prev) begin
            // Bank timers advance on every live internal edge
            for (int i = 0; i < 4; i++) begin
              if (st_ff.bank[i].cnt > 8'h01) begin
                nxt_st.bank[i].cnt = st_ff.bank[i].cnt - 8'h01;
              end else begin
                case (st_ff.bank[i].st)
                  BK_ACTV: nxt_st.bank[i].st = BK_ROW;
                  BK_PRE:  nxt_st.bank[i].st = BK_IDLE;
                  BK_RECOV: begin
                    nxt_st.bank[i].st  = BK_PRE;
                    nxt_st.bank[i].cnt = rp_c;
                  end
                  default: nxt_st.bank[i] = st_ff.bank[i];
                endcase
              end
            end
            if (!st_ff.pins_s2.cke && !st_ff.burst_act) begin
              // Low-power entries from a quiet device
              if (cmd == CMD_NOP || cmd == CMD_INH) begin
                nxt_st.pwr = PM_PDN;
              end else if (all_idle && cmd == CMD_BST) begin
                nxt_st.pwr = PM_DPD;
              end else if (all_idle && cmd == CMD_REF) begin
                nxt_st.pwr = PM_SREF;
              end else begin
                nxt_st.err[ERR_PWR_BIT] = 1'b1;
              end
            end else begin
              case (cmd)
                CMD_ACT: begin
                  if (nxt_st.bank[cba].st == BK_IDLE) begin
                    nxt_st.bank[cba].st  = BK_ACTV;
                    nxt_st.bank[cba].cnt = rcd_c;
                  end else begin
                    nxt_st.err[ERR_CMD_BIT] = 1'b1;
                  end
                end
                CMD_RD, CMD_WR: begin
                  bank_ok = (nxt_st.bank[cba].st == BK_ROW) ||
                            (nxt_st.bank[cba].st == BK_RD) ||
                            (nxt_st.bank[cba].st == BK_WR);
                  if (bank_ok) begin
                    go = 1'b1;
                    if (st_ff.burst_act) begin
                      // Interrupted auto-precharge bank runs its own precharge; a plain burst bank returns to row active
                      nxt_st.bank[st_ff.burst_bank] =
                        release_bank(nxt_st.bank[st_ff.burst_bank], rp_c, wr_c);
                    end
                    if (cmd == CMD_WR) begin
                      // Read data already in flight must not meet write data
                      nxt_st.pipe0 = '0;
                      nxt_st.pipe1 = '0;
                    end
                    nxt_st.bank[cba].st = (cmd == CMD_WR)
                      ? (st_ff.pins_s2.a10 ? BK_WRAP : BK_WR)
                      : (st_ff.pins_s2.a10 ? BK_RDAP : BK_RD);
                    nxt_st.burst_act  = 1'b1;
                    nxt_st.burst_wr   = (cmd == CMD_WR);
                    nxt_st.burst_bank = cba;
                    nxt_st.burst_left = st_ff.cfg[CFG_BL_LSB +: 3];
                  end else begin
                    nxt_st.err[ERR_CMD_BIT] = 1'b1;
                  end
                end
                CMD_PRE: begin
                  for (int i = 0; i < 4; i++) begin
                    if ((st_ff.pins_s2.a10 || cba == i[1:0]) &&
                        (nxt_st.bank[i].st == BK_ROW || nxt_st.bank[i].st == BK_RD ||
                         nxt_st.bank[i].st == BK_WR)) begin
                      nxt_st.bank[i].st  = BK_PRE;
                      nxt_st.bank[i].cnt = rp_c;
                      if (st_ff.burst_act && st_ff.burst_bank == i[1:0]) begin
                        nxt_st.burst_act = 1'b0;
                      end
                    end else if ((st_ff.pins_s2.a10 || cba == i[1:0]) &&
                                 nxt_st.bank[i].st != BK_IDLE) begin
                      nxt_st.err[ERR_CMD_BIT] = 1'b1;
                    end
                  end
                end
                CMD_BST: begin
                  // Whichever bank owns the latest burst
                  if (st_ff.burst_act) begin
                    nxt_st.burst_act = 1'b0;
                    nxt_st.bank[st_ff.burst_bank] =
                      release_bank(nxt_st.bank[st_ff.burst_bank], rp_c, wr_c);
                  end
                end
                CMD_REF, CMD_LMR: begin
                  // Refresh and mode load need all banks idle; otherwise they are flagged
                  if (!all_idle) nxt_st.err[ERR_CMD_BIT] = 1'b1;
                end
                default: nxt_st.err = nxt_st.err;
              endcase
              // Burst runs on; the first element belongs to the command edge
              if (!go && nxt_st.burst_act) begin
                if (st_ff.burst_left == 3'h0) begin
                  nxt_st.burst_act = 1'b0;
                  nxt_st.bank[st_ff.burst_bank] =
                    release_bank(nxt_st.bank[st_ff.burst_bank], rp_c, wr_c);
                end else begin
                  nxt_st.burst_left = st_ff.burst_left - 3'h1;
                end
              end
              if (go || (nxt_st.burst_act && st_ff.burst_act)) begin
                if (nxt_st.burst_wr) begin
                  // Masked elements are not stored
                  nxt_st.wr_store = ~st_ff.pins_s2.dqm;
                  nxt_st.wr_bank  = nxt_st.burst_bank;
                end
              end
              if (!st_ff.pins_s2.cke) nxt_st.pwr = PM_SUSP;
            end
            // Read data leaves read_latency edges after its element
            nxt_st.rd_drive = (cmd == CMD_WR && go) ? 1'b0
                              : sel.v & ~st_ff.dqm_prev;
            nxt_st.rd_bank  = sel.bank;
            if (!(cmd == CMD_WR && go)) begin
              nxt_st.pipe1 = st_ff.pipe0;
              nxt_st.pipe0.v    = nxt_st.burst_act & ~nxt_st.burst_wr &
                                  (go | st_ff.burst_act);
              nxt_st.pipe0.bank = nxt_st.burst_bank;
            end
          end
        end
        // Suspended edges freeze banks, burst and read pipeline; data stays driven
        PM_SUSP: if (st_ff.pins_s2.cke) nxt_st.pwr = PM_RUN;
        PM_PDN: begin
          if (st_ff.pins_s2.cke) begin
            if (cmd == CMD_NOP || cmd == CMD_INH) begin
              nxt_st.pwr = PM_RUN;
            end else begin
              nxt_st.err[ERR_PWR_BIT] = 1'b1;
            end
          end
        end
        PM_SREF: begin
          if (st_ff.pins_s2.cke) begin
            nxt_st.pwr  = PM_XSR;
            nxt_st.pcnt = sbc_cnt(st_ff.cfg[CFG_XSR_LSB +: 8]);
          end
        end
        PM_XSR: begin
          // Anything but idle commands while the array wakes is flagged
          if (cmd != CMD_NOP && cmd != CMD_INH) nxt_st.err[ERR_PWR_BIT] = 1'b1;
          if (st_ff.pcnt > 8'h01) nxt_st.pcnt = st_ff.pcnt - 8'h01;
          else nxt_st.pwr = PM_RUN;
        end
        PM_DPD: begin
          // Array is lost; controller must reinitialise afterwards
          if (st_ff.pins_s2.cke) nxt_st.pwr = PM_RUN;
        end
        default: nxt_st.pwr = PM_RUN;
      endcase
    end
    // Register slave: address phase captured, write applied in data phase
    if (st_ff.dph_wr) begin
      if (st_ff.dph_addr == REG_CFG) nxt_st.cfg = hwdata[CFG_W-1:0];
      // A hardware set of a clear flag wins over the software clear
      if (st_ff.dph_addr == REG_ERR) nxt_st.err = (st_ff.err & ~hwdata[1:0])
                                                  | (nxt_st.err & ~st_ff.err);
    end
    nxt_st.dph_wr   = ahb_take & hwrite;
    nxt_st.dph_addr = haddr[3:0];
    if (ahb_take && !hwrite) begin
      case (haddr[7:0])
        {4'h0, REG_CFG}:  nxt_st.hrdata = {8'h00, st_ff.cfg};
        {4'h0, REG_STAT}: nxt_st.hrdata = {12'h000, st_ff.burst_act, st_ff.pwr,
                                           st_ff.bank[3].st, st_ff.bank[2].st,
                                           st_ff.bank[1].st, st_ff.bank[0].st};
        {4'h0, REG_ERR}:  nxt_st.hrdata = {30'h00000000, st_ff.err};
        default:          nxt_st.hrdata = 32'h00000000;
      endcase
    end
    if (ahb_take && hwrite && haddr[31:4] != 28'h0000000) nxt_st.dph_wr = 1'b0;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff      <= '0;
      st_ff.cfg  <= CFG_RST;
      st_ff.pwr  <= PM_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_ff.hrdata;
  assign rd_drive  = st_ff.rd_drive;
  assign rd_bank   = st_ff.rd_bank;
  assign wr_store  = st_ff.wr_store;
  assign wr_bank   = st_ff.wr_bank;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  rdap_precharge_a: assert property (intr && cmd == CMD_RD &&
      st_ff.bank[st_ff.burst_bank].st == BK_RDAP
      |=> st_ff.bank[$past(st_ff.burst_bank)].st == BK_PRE)
    else $error("interrupted auto-precharge read did not precharge");
  rdap_wr_stop_a: assert property (intr && cmd == CMD_WR &&
      st_ff.bank[st_ff.burst_bank].st == BK_RDAP
      |=> !st_ff.rd_drive && !st_ff.pipe0.v && !st_ff.pipe1.v
          && st_ff.bank[$past(st_ff.burst_bank)].st == BK_PRE)
    else $error("write did not stop auto-precharge read");
  wrap_recover_a: assert property (intr &&
      st_ff.bank[st_ff.burst_bank].st == BK_WRAP
      |=> st_ff.bank[$past(st_ff.burst_bank)].st == BK_RECOV)
    else $error("interrupted auto-precharge write skipped recovery");
  wr_switch_a: assert property (intr && cmd == CMD_WR && !st_ff.pins_s2.dqm
      |=> st_ff.wr_store && st_ff.wr_bank == $past(cba))
    else $error("write data not steered to new bank");
  pd_exit_a: assert property (lk_edge && st_ff.pwr == PM_PDN && st_ff.pins_s2.cke
      && cmd == CMD_NOP |=> st_ff.pwr == PM_RUN)
    else $error("power-down exit late");
  susp_exit_a: assert property (lk_edge && st_ff.pwr == PM_SUSP
      && st_ff.pins_s2.cke |=> st_ff.pwr == PM_RUN)
    else $error("clock suspend exit late");
  dpd_entry_a: assert property (lk_edge && st_ff.pwr == PM_RUN && st_ff.cke_prev
      && !st_ff.pins_s2.cke && all_idle && cmd == CMD_BST |=> st_ff.pwr == PM_DPD)
    else $error("deep power-down not entered");
  row_delay_a: assert property (st_ff.bank[0].st == BK_ROW
      && $past(st_ff.bank[0].st) == BK_ACTV |-> $past(st_ff.bank[0].cnt) == 8'h01)
    else $error("row active before delay elapsed");
  pre_period_a: assert property (st_ff.bank[0].st == BK_IDLE
      && $past(st_ff.bank[0].st) == BK_PRE |-> $past(st_ff.bank[0].cnt) == 8'h01)
    else $error("bank idle before precharge period");

  rd_intr_c: cover property (intr && cmd == CMD_RD);
  wr_intr_c: cover property (intr && cmd == CMD_WR);
  pd_cycle_c: cover property (st_ff.pwr == PM_PDN ##[1:200] st_ff.pwr == PM_RUN);
  susp_c: cover property (st_ff.pwr == PM_SUSP);

endmodule
`default_nettype wire

// >>> sim/sbc_ctrl_model.sv
// Memory controller model: device clock and command pins
`timescale 1ns/100ps
`default_nettype none
module sbc_ctrl_model
  import sbc_pkg::*;
(
  input  wire logic     clock,
  output var  logic     link_clk,
  output var  sbc_pins_t pins
);
  ////////////////////////////////////////////////////////////////////////
  // Idle: deselected, clock enable high, no mask
  initial begin
    link_clk = 1'b0;
    pins     = 9'h1F0;
  end

  // One device clock per command; it stands low between commands.
  // Pins settle four system clocks before and after each rising edge.
  // Callers issue legal sequences, bar the t_err read to an idle bank: no command to busy banks,
  // refresh or mode load only with all banks idle
  // Clock enable never low with a terminate code here
  task automatic issue(input sbc_pins_t p);
    pins <= p;
    repeat (4) @(posedge clock);
    link_clk <= 1'b1;
    repeat (4) @(posedge clock);
    link_clk <= 1'b0;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// >>> sim/sbc_bank_ctrl_tb.sv
// Self-checking testbench for the bank command state logic
`timescale 1ns/100ps
`default_nettype none
module sbc_bank_ctrl_tb
  import sbc_pkg::*;
;
  localparam logic [2:0] C_ACT = 3'h3;
  localparam logic [2:0] C_RD  = 3'h5;
  localparam logic [2:0] C_WR  = 3'h4;
  localparam logic [2:0] C_PRE = 3'h2;
  localparam logic [2:0] C_NOP = 3'h7;

  logic        clock = 1'b0;
  logic        srst;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        link_clk;
  sbc_pins_t   pins;
  logic        rd_drive;
  logic [1:0]  rd_bank;
  logic        wr_store;
  logic [1:0]  wr_bank;
  logic [31:0] r;
  logic [1:0]  ws_bank;
  int          ws_cnt;
  int          miscompares;
  int          check_count;

  always #25 clock = ~clock;

  sbc_bank_ctrl sbc_bank_ctrl_inst (
    .clock(clock), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_clk(link_clk),
    .pins_in(pins), .rd_drive(rd_drive), .rd_bank(rd_bank), .wr_store(wr_store),
    .wr_bank(wr_bank));

  sbc_ctrl_model sbc_ctrl_model_inst (.clock(clock), .link_clk(link_clk), .pins(pins));

  // Store pulses last one cycle, so they are counted here
  always @(posedge clock) begin
    if (wr_store === 1'b1) begin
      ws_cnt  <= ws_cnt + 1;
      ws_bank <= wr_bank;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    int i;
    i = 0;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do begin @(posedge clock); i++; end while (hreadyout !== 1'b1 && i < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clock); i++; end while (hreadyout !== 1'b1 && i < 40);
    q = hrdata;
    // Timeout counts and lets the sequence run on to the closing report
    if (i >= 40) miscompares++;
  endtask

  task cmd(input logic [2:0] rcw, input logic [1:0] ba, input logic a10);
    sbc_ctrl_model_inst.issue({1'b0, rcw, 1'b1, 1'b0, ba, a10});
  endtask

  task st(input int b, input logic [3:0] e);
    bus(1'b0, 32'h4, 32'h0, r);
    chk({28'h0, r[4*b+:4]}, {28'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    bus(1'b0, 32'h0, 32'h0, r);
    chk(r, 32'h00082216);
    bus(1'b1, 32'h4, 32'hFFFFFFFF, r);
    bus(1'b0, 32'h4, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, 32'h40, 32'h0, r);
    chk(r, 32'h0);
  endtask

  task t_read;
    cmd(C_NOP, 2'h0, 1'b0);
    cmd(C_ACT, 2'h0, 1'b0);
    st(0, 4'h1);
    cmd(C_NOP, 2'h0, 1'b0);
    st(0, 4'h1);
    cmd(C_RD, 2'h0, 1'b0);
    st(0, 4'h3);
    cmd(C_NOP, 2'h0, 1'b0);
    chk({29'h0, rd_bank, rd_drive}, 32'h1);
    cmd(C_PRE, 2'h0, 1'b0);
    st(0, 4'h8);
    cmd(C_NOP, 2'h0, 1'b0);
    st(0, 4'h8);
    cmd(C_NOP, 2'h0, 1'b0);
    st(0, 4'h0);
  endtask

  // Write with auto precharge cut short by a write to another bank
  task t_wrap;
    cmd(C_ACT, 2'h0, 1'b0);
    cmd(C_ACT, 2'h1, 1'b0);
    cmd(C_WR, 2'h0, 1'b1);
    st(0, 4'h6);
    ws_cnt = 0;
    cmd(C_WR, 2'h1, 1'b0);
    st(0, 4'h7);
    chk(ws_cnt, 32'h1);
    chk({30'h0, ws_bank}, 32'h1);
    cmd(C_NOP, 2'h0, 1'b0);
    st(0, 4'h8);
    cmd(C_NOP, 2'h0, 1'b0);
    cmd(C_NOP, 2'h0, 1'b0);
    st(0, 4'h0);
  endtask

  task t_pdn;
    // Let the bank 1 burst finish, else clock-enable low means suspend
    cmd(C_NOP, 2'h0, 1'b0);
    sbc_ctrl_model_inst.issue(9'h1E0);
    bus(1'b0, 32'h4, 32'h0, r);
    chk({29'h0, r[18:16]}, 32'h1);
    sbc_ctrl_model_inst.issue(9'h1F0);
    cmd(C_ACT, 2'h2, 1'b0);
    st(2, 4'h1);
  endtask

  // Read to an idle bank is refused and flagged
  task t_err;
    cmd(C_RD, 2'h3, 1'b0);
    bus(1'b0, 32'h8, 32'h0, r);
    chk({31'h0, r[0]}, 32'h1);
    bus(1'b1, 32'h8, 32'h1, r);
    bus(1'b0, 32'h8, 32'h0, r);
    chk({31'h0, r[0]}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst   = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_regs;
    t_read;
    t_wrap;
    t_pdn;
    t_err;
    report_and_stop;
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
